// *** rtl/adcc_pkg.sv ***
// Shared constants, types and helpers of the converter register bank.
// Assumes a single core clock; modulator timing arrives as a tick enable.
package adcc_pkg;

    // ========================================================================
    // Register addresses
    localparam logic [4:0] ADDR_STATUS = 5'h0C;
    localparam logic [4:0] ADDR_CFG0 = 5'h0D;
    localparam logic [4:0] ADDR_CFG1 = 5'h0E;
    localparam logic [4:0] ADDR_OFF0 = 5'h0F;
    localparam logic [4:0] ADDR_GAIN0 = 5'h10;
    localparam logic [4:0] ADDR_OFF1 = 5'h11;
    localparam logic [4:0] ADDR_GAIN1 = 5'h12;
    localparam logic [4:0] ADDR_LOCK = 5'h1F;

    // ========================================================================
    // Values after reset and writable-bit masks
    localparam logic [23:0] RST_STATUS = 24'hA90000;
    localparam logic [23:0] MASK_STATUS = 24'hFFC800;
    localparam logic [23:0] RST_CFG0 = 24'h386050;
    localparam logic [23:0] MASK_CFG0 = 24'hFFE0FF;
    localparam logic [23:0] RST_CFG1 = 24'h000040;
    localparam logic [23:0] MASK_CFG1 = 24'h0303C0;
    localparam logic [23:0] RST_CAL = 24'h000000;
    localparam logic [1:0] RST_READY_N = 2'h3;
    localparam logic [7:0] LOCK_PASSWORD = 8'hA5;

    // ========================================================================
    // Field positions (lowest bit of each field)
    localparam int ST_DR_HIZ = 20;
    localparam int ST_EN_INT = 14;
    localparam int ST_EN_BITSTREAM = 11;
    localparam int C0_EN_OFF = 23;
    localparam int C0_EN_GAIN = 22;
    localparam int C0_IDLE_TONE_NOISE_STRENGTH = 20;
    localparam int C0_BIAS = 18;
    localparam int C0_PRESCALE = 16;
    localparam int C0_OSR = 13;
    localparam int C0_TRIM = 0;
    localparam int C1_SOFT_RESET = 16;
    localparam int C1_SHUTDOWN = 8;
    localparam int C1_EXT_REF = 7;
    localparam int C1_EXT_CLK = 6;
    localparam int LOCK_POS = 16;

    // ========================================================================
    // Timing in modulator clock periods
    localparam logic [4:0] GAIN_DELAY_TICKS = 5'h18;
    localparam logic [4:0] TICK_ONE = 5'h01;
    localparam logic [12:0] OSR_BASE = 13'h0020;
    localparam logic [2:0] PRESCALE_ZERO = 3'h0;

    // ========================================================================
    // Carriers
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [23:0] wdata;
    } adcc_reg_req_type;

    typedef struct packed {
        logic valid;
        logic signed [23:0] code;
    } adcc_code_type;

    typedef struct packed {
        logic [1:0] noise_strength;
        logic [1:0] bias_current_select;
        logic [1:0] prescale;
        logic [2:0] osr_code;
        logic [12:0] oversampling_ratio;
        logic [1:0] soft_reset;
        logic [1:0] shutdown;
        logic external_reference_select;
        logic internal_reference_enable;
        logic external_clock_select;
        logic crystal_enable;
        logic [7:0] reference_tempco_trim;
    } adcc_analog_ctrl_type;

    // ========================================================================
    // Helpers
    function automatic logic signed [23:0] adcc_sat24(input logic signed [49:0] v);
        if (v > 50'sh7FFFFF) begin
            return 24'sh7FFFFF;
        end else if (v < -50'sh800000) begin
            return 24'sh800000;
        end
        return v[23:0];
    endfunction

    function automatic logic [12:0] adcc_osr_ratio(input logic [2:0] code);
        return OSR_BASE << code;
    endfunction

endpackage

// *** rtl/adcc_cal.sv ***
// One channel of offset and gain correction on converter output codes.
// Assumes raw codes arrive as single-cycle valid words on the core clock.
`timescale 1ns/100ps
module adcc_cal (
    // Clock and control
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_mod_tick,
    input wire logic i_hold,
    // Correction settings
    input wire logic i_offset_correction_enable,
    input wire logic i_gain_correction_enable,
    input wire logic [23:0] i_offset_correction_value,
    input wire logic [23:0] i_gain_correction_value,
    // Data
    input wire adcc_pkg::adcc_code_type i_raw,
    output adcc_pkg::adcc_code_type o_out
);
    import adcc_pkg::*;

    logic signed [23:0] next_offset_code;
    logic signed [24:0] gain_plus_one;
    logic signed [49:0] product;
    logic signed [23:0] gain_result;
    logic pending;
    logic [4:0] tick_count;

    // ========================================================================
    // Arithmetic
    always_comb begin
        next_offset_code = i_raw.code;
        if (i_offset_correction_enable) begin
            next_offset_code = adcc_sat24(50'(i_raw.code) + 50'($signed(i_offset_correction_value))); // [R20]
        end
        gain_plus_one = 25'($signed(i_gain_correction_value)) + 25'sh0800000; // [R21]
        product = 50'(next_offset_code) * 50'(gain_plus_one); // [R21]
    end

    // ========================================================================
    // Output and gain delay
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_out <= '0;
            pending <= 1'b0;
            tick_count <= '0;
            gain_result <= '0;
        end else if (i_ce) begin
            o_out.valid <= 1'b0;
            if (i_hold) begin
                pending <= 1'b0;
            end else if (i_raw.valid && !i_gain_correction_enable) begin
                // Offset path adds no stage past the output register.
                o_out <= '{valid: 1'b1, code: next_offset_code}; // [R09] [R22]
            end else if (i_raw.valid) begin
                gain_result <= adcc_sat24(product >>> 23); // [R21]
                pending <= 1'b1;
                tick_count <= GAIN_DELAY_TICKS; // [R10]
            end else if (pending && i_mod_tick) begin
                tick_count <= tick_count - TICK_ONE;
                if (tick_count == TICK_ONE) begin
                    o_out <= '{valid: 1'b1, code: gain_result}; // [R10]
                    pending <= 1'b0;
                end
            end
        end
    end

endmodule // adcc_cal

// *** rtl/adcc_regs.sv ***
// Configuration, status and calibration registers of a two-channel converter.
// Assumes one register request per cycle and inputs on the core clock.
//
// Contract
// R01: Enabled checksum error holds ready pin low.
// R02: Password write clears checksum interrupt.
// R03: Password unlocks all writes, clears checksum.
// R04: Host writes zero to reserved status bits.
// R05: Bitstream enable drives outputs, else floats.
// R06: Per-channel ready flag, one means no data.
// R07: Status read sets ready flags back to one.
// R08: Reading channel data leaves ready flags alone.
// R09: Offset correction adds no group delay.
// R10: Gain correction delays data by 24 ticks.
// R11: Two-bit idle_tone_noise_strength strength, default maximum.
// R12: Two-bit bias current select, default x1.
// R13: Prescaler divides master clock by 1/2/4/8.
// R14: Oversampling ratio 32 to 4096, default 256.
// R15: Per-channel soft reset while bit is one.
// R16: Per-channel shutdown while bit is one.
// R17: External reference select stops internal reference.
// R18: External clock select disables crystal oscillator.
// R19: Eight-bit reference tempco trim in low byte.
// R20: Offset value added to channel code.
// R21: Gain multiplies by one plus value.
// R22: Disabled correction ignores but keeps values.
`timescale 1ns/100ps
module adcc_regs #(
    parameter int CHANNELS = 2
) (
    // Clock, reset and enable
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // Register access port
    input wire adcc_pkg::adcc_reg_req_type i_req,
    output logic [23:0] o_rdata,
    output logic o_rvalid,
    // Checksum engine
    input wire logic i_map_checksum_error,
    input wire logic [15:0] i_map_checksum_value,
    output logic o_checksum_run,
    // Converter side
    input wire logic i_mod_tick,
    input wire adcc_pkg::adcc_code_type i_raw_ch0,
    input wire adcc_pkg::adcc_code_type i_raw_ch1,
    input wire logic [1:0] i_mod_bits,
    // Corrected data
    output adcc_pkg::adcc_code_type o_data_ch0,
    output adcc_pkg::adcc_code_type o_data_ch1,
    // Pins
    output logic o_data_ready_pin,
    output logic o_data_ready_pin_oe,
    output logic [1:0] o_bitstream_outputs,
    output logic [1:0] o_bitstream_outputs_oe,
    // Analog controls
    output adcc_pkg::adcc_analog_ctrl_type o_analog,
    output logic o_analog_master_clock_tick,
    output logic [15:0] o_comm_settings
);
    import adcc_pkg::*;

    logic [23:0] status_cfg;
    logic [23:0] config_zero;
    logic [23:0] config_one;
    logic [23:0] offset_value [CHANNELS];
    logic [23:0] gain_value [CHANNELS];
    logic [7:0] lock_code;
    logic checksum_irq;
    logic [1:0] ready_n;
    logic ready_pulse;
    logic [2:0] prescale_count;
    logic [2:0] prescale_limit;
    logic unlocked;
    logic write_ok;
    logic [1:0] channel_hold;
    adcc_code_type cal_out [CHANNELS];
    adcc_code_type raw_in [CHANNELS];

    // ========================================================================
    // Lock state and write qualification
    assign unlocked = (lock_code == LOCK_PASSWORD); // [R03]
    assign write_ok = i_req.wr && (unlocked || (i_req.addr == ADDR_LOCK)); // [R03]
    assign o_checksum_run = !unlocked; // [R03]
    assign raw_in[0] = i_raw_ch0;
    assign raw_in[1] = i_raw_ch1;

    // ========================================================================
    // Configuration registers
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            status_cfg <= RST_STATUS;
            config_zero <= RST_CFG0;
            config_one <= RST_CFG1;
            lock_code <= LOCK_PASSWORD;
        end else if (i_ce && write_ok) begin
            case (i_req.addr)
                ADDR_STATUS: begin
                    // Reserved bits 13:12 are not stored and read as zero.
                    status_cfg <= i_req.wdata & MASK_STATUS;
                end
                ADDR_CFG0: begin
                    config_zero <= i_req.wdata & MASK_CFG0; // [R11] [R12] [R13] [R14] [R19]
                end
                ADDR_CFG1: begin
                    config_one <= i_req.wdata & MASK_CFG1; // [R15] [R16] [R17] [R18]
                end
                ADDR_LOCK: begin
                    lock_code <= i_req.wdata[LOCK_POS +: 8];
                end
                default: begin
                end
            endcase
        end
    end

    // ========================================================================
    // Calibration values, kept across enable changes
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            for (int n = 0; n < CHANNELS; n++) begin
                offset_value[n] <= RST_CAL;
                gain_value[n] <= RST_CAL;
            end
        end else if (i_ce && write_ok) begin
            case (i_req.addr)
                ADDR_OFF0: begin
                    offset_value[0] <= i_req.wdata; // [R22]
                end
                ADDR_GAIN0: begin
                    gain_value[0] <= i_req.wdata; // [R22]
                end
                ADDR_OFF1: begin
                    offset_value[1] <= i_req.wdata; // [R22]
                end
                ADDR_GAIN1: begin
                    gain_value[1] <= i_req.wdata; // [R22]
                end
                default: begin
                end
            endcase
        end
    end

    // ========================================================================
    // Checksum interrupt flag
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            checksum_irq <= 1'b0;
        end else if (i_ce) begin
            if (unlocked) begin
                // Unlocked stops the checksum, so the clear wins.
                checksum_irq <= 1'b0; // [R02] [R03]
            end else if (status_cfg[ST_EN_INT] && i_map_checksum_error) begin
                checksum_irq <= 1'b1; // [R01]
            end
        end
    end

    // ========================================================================
    // Per-channel ready flags
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            ready_n <= RST_READY_N;
        end else if (i_ce) begin
            for (int n = 0; n < CHANNELS; n++) begin
                if (cal_out[n].valid) begin
                    // New data wins over a status read in the same cycle.
                    ready_n[n] <= 1'b0; // [R06]
                end else if (i_req.rd && i_req.addr == ADDR_STATUS) begin
                    ready_n[n] <= 1'b1; // [R07]
                end
            end
        end
    end

    // ========================================================================
    // Read port
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_rdata <= '0;
            o_rvalid <= 1'b0;
        end else if (i_ce) begin
            o_rvalid <= i_req.rd;
            o_rdata <= '0;
            if (i_req.rd) begin
                case (i_req.addr)
                    ADDR_STATUS: begin
                        o_rdata <= status_cfg | {22'h000000, ready_n}; // [R06]
                    end
                    ADDR_LOCK: begin
                        o_rdata <= {lock_code, unlocked ? 16'h0000 : i_map_checksum_value}; // [R03]
                    end
                    // Other registers read as zero while locked.
                    ADDR_CFG0: begin
                        o_rdata <= unlocked ? config_zero : '0;
                    end
                    ADDR_CFG1: begin
                        o_rdata <= unlocked ? config_one : '0;
                    end
                    ADDR_OFF0: begin
                        o_rdata <= unlocked ? offset_value[0] : '0;
                    end
                    ADDR_GAIN0: begin
                        o_rdata <= unlocked ? gain_value[0] : '0;
                    end
                    ADDR_OFF1: begin
                        o_rdata <= unlocked ? offset_value[1] : '0;
                    end
                    ADDR_GAIN1: begin
                        o_rdata <= unlocked ? gain_value[1] : '0;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ========================================================================
    // Correction datapaths
    assign channel_hold = config_one[C1_SOFT_RESET +: 2] | config_one[C1_SHUTDOWN +: 2]; // [R15] [R16]

    for (genvar n = 0; n < CHANNELS; n++) begin : g_cal
        adcc_cal u_cal (
            .i_core_clk(i_core_clk),
            .i_rst_b(i_rst_b),
            .i_ce(i_ce),
            .i_mod_tick(i_mod_tick),
            .i_hold(channel_hold[n]),
            .i_offset_correction_enable(config_zero[C0_EN_OFF]),
            .i_gain_correction_enable(config_zero[C0_EN_GAIN]),
            .i_offset_correction_value(offset_value[n]),
            .i_gain_correction_value(gain_value[n]),
            .i_raw(raw_in[n]),
            .o_out(cal_out[n])
        );
    end

    // Data reads never touch the ready flags.
    assign o_data_ch0 = cal_out[0]; // [R08]
    assign o_data_ch1 = cal_out[1]; // [R08]

    // ========================================================================
    // Data-ready pin and bitstream outputs
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            ready_pulse <= 1'b0;
            o_bitstream_outputs <= 2'h0;
        end else if (i_ce) begin
            ready_pulse <= cal_out[0].valid | cal_out[1].valid; // [R10]
            o_bitstream_outputs <= i_mod_bits;
        end
    end

    assign o_data_ready_pin = !(checksum_irq || ready_pulse); // [R01]
    assign o_data_ready_pin_oe = !o_data_ready_pin || status_cfg[ST_DR_HIZ];
    assign o_bitstream_outputs_oe = {2{status_cfg[ST_EN_BITSTREAM]}}; // [R05]
    assign o_comm_settings = status_cfg[23:8];

    // ========================================================================
    // Analog master clock prescaler
    assign prescale_limit = 3'((4'h1 << config_zero[C0_PRESCALE +: 2]) - 4'h1); // [R13]

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            prescale_count <= PRESCALE_ZERO;
            o_analog_master_clock_tick <= 1'b0;
        end else if (i_ce) begin
            o_analog_master_clock_tick <= (prescale_count >= prescale_limit); // [R13]
            if (prescale_count >= prescale_limit) begin
                prescale_count <= PRESCALE_ZERO;
            end else begin
                prescale_count <= prescale_count + 3'h1;
            end
        end
    end

    // ========================================================================
    // Analog control decode
    always_comb begin
        o_analog.noise_strength = config_zero[C0_IDLE_TONE_NOISE_STRENGTH +: 2]; // [R11]
        o_analog.bias_current_select = config_zero[C0_BIAS +: 2]; // [R12]
        o_analog.prescale = config_zero[C0_PRESCALE +: 2]; // [R13]
        o_analog.osr_code = config_zero[C0_OSR +: 3];
        o_analog.oversampling_ratio = adcc_osr_ratio(config_zero[C0_OSR +: 3]); // [R14]
        o_analog.soft_reset = config_one[C1_SOFT_RESET +: 2]; // [R15]
        o_analog.shutdown = config_one[C1_SHUTDOWN +: 2]; // [R16]
        o_analog.external_reference_select = config_one[C1_EXT_REF]; // [R17]
        o_analog.internal_reference_enable = !config_one[C1_EXT_REF]; // [R17]
        o_analog.external_clock_select = config_one[C1_EXT_CLK]; // [R18]
        o_analog.crystal_enable = !config_one[C1_EXT_CLK]; // [R18]
        o_analog.reference_tempco_trim = config_zero[C0_TRIM +: 8]; // [R19]
    end

endmodule // adcc_regs

// *** test/adcc_host_model.sv ***
// Host side model: issues single-cycle register requests on the access port.
// Assumes callers resume on a rising clock edge and never overlap calls.
`timescale 1ns/100ps
module adcc_host_model (
    // Clock
    input wire logic i_core_clk,
    // Request
    output adcc_pkg::adcc_reg_req_type o_req
);
    import adcc_pkg::*;
    initial o_req = '0;
    // ========================================================================
    // Request task
    // Holds the request for exactly one sampling edge.
    task automatic put(input logic w, input logic r, input logic [4:0] a, input logic [23:0] d);
        @(posedge i_core_clk);
        o_req <= '{w, r, a, (a == ADDR_STATUS) ? (d & 24'hFFCFFF) : d};
        @(posedge i_core_clk);
        o_req <= '0;
    endtask
endmodule // adcc_host_model

// *** test/adcc_regs_props.sv ***
// Port checker of the converter register bank.
// Assumes one core clock and the bank's synchronous active-low reset.
`timescale 1ns/100ps
module adcc_regs_props (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // Watched ports
    input wire adcc_pkg::adcc_reg_req_type i_req,
    input wire logic [23:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic o_checksum_run,
    input wire adcc_pkg::adcc_code_type o_data_ch0,
    input wire adcc_pkg::adcc_code_type o_data_ch1,
    input wire logic o_data_ready_pin,
    input wire logic o_data_ready_pin_oe,
    input wire logic [1:0] o_bitstream_outputs_oe,
    input wire adcc_pkg::adcc_analog_ctrl_type o_analog,
    input wire logic o_analog_master_clock_tick
);
    import adcc_pkg::*;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    // ========================================================================
    // Sequences
    sequence s_quiet;
        !o_data_ch0.valid && !o_data_ch1.valid;
    endsequence
    sequence s_stat_rd;
        (i_ce && i_req.rd && i_req.addr == ADDR_STATUS) and s_quiet;
    endsequence
    // ========================================================================
    // Assertions
    a_flags_set_back: assert property (s_stat_rd ##1 s_quiet ##1 s_stat_rd |=> o_rvalid && o_rdata[1:0] == 2'h3)
        else $error("ready flags not set back");
    a_pin_after_data: assert property ((o_data_ch0.valid || o_data_ch1.valid) && i_ce |=> !o_data_ready_pin)
        else $error("no ready pulse");
    a_pin_low_driven: assert property (!o_data_ready_pin |-> o_data_ready_pin_oe)
        else $error("ready pin low undriven");
    a_bits_oe_pair: assert property (o_bitstream_outputs_oe[0] == o_bitstream_outputs_oe[1])
        else $error("bitstream enables differ");
    a_osr_decode: assert property (o_analog.oversampling_ratio == (13'h0020 << o_analog.osr_code))
        else $error("oversampling ratio wrong");
    a_ref_select: assert property (o_analog.internal_reference_enable != o_analog.external_reference_select)
        else $error("reference select wrong");
    a_clock_select: assert property (o_analog.crystal_enable != o_analog.external_clock_select)
        else $error("clock select wrong");
    a_unlock_clears: assert property (i_ce && i_req.wr && i_req.addr == ADDR_LOCK && i_req.wdata[23:16] == LOCK_PASSWORD |=> !o_checksum_run)
        else $error("checksum runs after unlock");
    a_prescale_tick: assert property ((i_ce && o_analog.prescale == 2'h0) [*8] |-> o_analog_master_clock_tick)
        else $error("prescaler tick missing");
endmodule // adcc_regs_props

bind adcc_regs adcc_regs_props u_props (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_req(i_req),
    .o_rdata(o_rdata),
    .o_rvalid(o_rvalid),
    .o_checksum_run(o_checksum_run),
    .o_data_ch0(o_data_ch0),
    .o_data_ch1(o_data_ch1),
    .o_data_ready_pin(o_data_ready_pin),
    .o_data_ready_pin_oe(o_data_ready_pin_oe),
    .o_bitstream_outputs_oe(o_bitstream_outputs_oe),
    .o_analog(o_analog),
    .o_analog_master_clock_tick(o_analog_master_clock_tick)
);

// *** test/adcc_regs_test.sv ***
// Self-checking bench of the register bank, driven through the host model.
// Assumes the package compiles first and the checker binds itself.
`timescale 1ns/100ps
module adcc_regs_test;
    import adcc_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic ce = 1'b1;
    logic tick = 1'b1;
    logic err = 1'b0;
    logic [15:0] cval = 16'h0000;
    logic [1:0] mbits = 2'h0;
    adcc_code_type raw0 = '0;
    adcc_code_type raw1 = '0;
    adcc_reg_req_type req;
    logic [23:0] o_rdata;
    logic o_rvalid, o_run, o_pin, o_pin_oe, o_mtick;
    logic [1:0] o_bits, o_bits_oe;
    adcc_code_type o_d0, o_d1;
    adcc_analog_ctrl_type o_an;
    int err_count = 0;
    int num_checks = 0;
    int seed = 29035;
    logic [23:0] q[$];
    logic [23:0] dq[$];
    always #10 i_core_clk = ~i_core_clk;
    adcc_host_model host (.i_core_clk(i_core_clk), .o_req(req));
    adcc_regs DUT (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_ce(ce), .i_req(req),
        .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_map_checksum_error(err),
        .i_map_checksum_value(cval), .o_checksum_run(o_run), .i_mod_tick(tick),
        .i_raw_ch0(raw0), .i_raw_ch1(raw1), .i_mod_bits(mbits), .o_data_ch0(o_d0),
        .o_data_ch1(o_d1), .o_data_ready_pin(o_pin), .o_data_ready_pin_oe(o_pin_oe),
        .o_bitstream_outputs(o_bits), .o_bitstream_outputs_oe(o_bits_oe),
        .o_analog(o_an), .o_analog_master_clock_tick(o_mtick), .o_comm_settings()
    );
    // ========================================================================
    // Helpers
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    function automatic logic [23:0] sat(input logic signed [49:0] v);
        if (v > 50'sh7FFFFF) return 24'h7FFFFF;
        if (v < -50'sh800000) return 24'h800000;
        return v[23:0];
    endfunction
    function automatic logic [23:0] gmul(input logic [23:0] x, input logic [23:0] g);
        return sat((50'($signed(x)) * (50'sh800000 + 50'($signed(g)))) >>> 23);
    endfunction
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        host.put(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [23:0] e);
        q.push_back(e);
        host.put(1'b0, 1'b1, a, 24'h000000);
    endtask
    // Sends a code on both channels and times channel 0.
    task automatic send(input logic [23:0] c, input logic [23:0] e, input int lat);
        int n;
        dq.push_back(e);
        @(posedge i_core_clk);
        raw0 <= '{1'b1, c};
        raw1 <= '{1'b1, c};
        @(posedge i_core_clk);
        raw0 <= '0;
        raw1 <= '0;
        n = 0;
        #1;
        while (o_d0.valid !== 1'b1 && n < 60) begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        check(24'(n), 24'(lat));
        if (n == 60) stop_test();
    endtask
    // ========================================================================
    // Output monitors
    always @(posedge i_core_clk) begin
        mbits <= 2'($random(seed));
        cval <= 16'($random(seed));
        if (o_rvalid === 1'b1) check(o_rdata, q.size() ? q.pop_front() : 24'hX);
        if (o_d0.valid === 1'b1) check(o_d0.code, dq.size() ? dq.pop_front() : 24'hX);
    end
    initial begin
        repeat (20000) @(posedge i_core_clk);
        err_count++;
        stop_test();
    end
    // ========================================================================
    // Main sequence
    initial begin
        logic [23:0] v, c, g;
        int n;
        repeat (5) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        rd(ADDR_STATUS, 24'hA90003);
        rd(ADDR_CFG0, 24'h386050);
        rd(ADDR_CFG1, 24'h000040);
        for (int a = 15; a < 19; a++) rd(5'(a), 24'h000000);
        check(24'(o_bits_oe), 24'h000000);
        $display("reset values done");
        for (int k = 0; k < 8; k++) begin
            v = {2'h0, {3{k[1:0]}}, k[2:0], 5'h00, 8'($random(seed))};
            wr(ADDR_CFG0, v);
            rd(ADDR_CFG0, v);
            check(24'(o_an[28:16]), 24'h000020 << k);
            check(24'(o_an[37:32]), 24'({3{k[1:0]}}));
            check(24'(o_an[7:0]), 24'(v[7:0]));
            n = 0;
            repeat (16) begin
                @(posedge i_core_clk);
                n += int'(o_mtick);
            end
            check(24'(n), 24'(16 >> k[1:0]));
        end
        $display("config zero done");
        for (int k = 0; k < 4; k++) begin
            v = {6'h0, k[1:0], 6'h0, ~k[1:0], k[0], k[1], 6'h00};
            wr(ADDR_CFG1, v);
            rd(ADDR_CFG1, v);
            check(24'(o_an[15:12]), 24'({k[1:0], ~k[1:0]}));
            check(24'(o_an[11:8]), 24'({k[0], ~k[0], k[1], ~k[1]}));
        end
        wr(ADDR_CFG1, 24'h000040);
        $display("config one done");
        wr(ADDR_STATUS, 24'hA97800);
        rd(ADDR_STATUS, 24'hA94803);
        check(24'(o_bits_oe), 24'h000003);
        $display("status done");
        v = 24'($random(seed));
        c = 24'($random(seed));
        wr(ADDR_OFF0, v);
        wr(ADDR_CFG0, 24'hB86050);
        send(c, sat(50'($signed(c)) + 50'($signed(v))), 0);
        rd(ADDR_STATUS, 24'hA94800);
        rd(ADDR_STATUS, 24'hA94803);
        wr(ADDR_OFF0, 24'h7FFFFF);
        send(24'h000100, 24'h7FFFFF, 0);
        $display("offset done");
        g = 24'($random(seed));
        wr(ADDR_GAIN0, g);
        wr(ADDR_CFG0, 24'hF86050);
        send(c, gmul(sat(50'($signed(c)) + 50'sh7FFFFF), g), 24);
        wr(ADDR_CFG0, 24'h386050);
        send(c, c, 0);
        rd(ADDR_OFF0, 24'h7FFFFF);
        rd(ADDR_GAIN0, g);
        $display("gain done");
        wr(ADDR_LOCK, 24'h000000);
        wr(ADDR_CFG0, 24'h000000);
        err <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        #1;
        check(24'(o_pin), 24'h000000);
        rd(ADDR_CFG0, 24'h000000);
        wr(ADDR_LOCK, 24'hA50000);
        @(posedge i_core_clk);
        #1;
        check(24'(o_pin), 24'h000001);
        rd(ADDR_CFG0, 24'h386050);
        err <= 1'b0;
        $display("lock done");
        repeat (4) @(posedge i_core_clk);
        stop_test();
    end
endmodule // adcc_regs_test
